// ### src/pces_top.sv
// Functional notes
// - Select zero holds the counter; select field is seven bits, 128 codes.
// - Counting starts on control write; stops when cleared or interrupt raised.
// - Code 1 adds one every clock cycle.
// - Code 2 adds completed instructions per cycle, zero to three.
// - Code 3 counts rising edges of the chosen timebase bit.
// - Code 4 adds dispatched instructions per cycle, zero to three.
// - Code 5 counts onsets of the monitor exception condition.
// - Code 7 counts rising edges of the external monitor input.
// - Codes 8-13 count vector unit and vector register move completions.
// - Codes 14-17 count vector reservation station operand-wait cycles.
// - Code 18 counts held status reads; code 19 saturation flag rises.
// - Code 20 counts completed stores, one per multiple or string.
// - Codes 21 and 41 count instruction cache misses and accesses.
// - Codes 22, 44, 48, 49, 50 count data cache snoop events.
// - Codes 23-27 count branch events including speculative ones.
// - Code 28 counts issue-queue dispatches; code 29 triple-dispatch cycles.
// - Codes 30, 31 count cycles queue fill reaches unscaled threshold.
// - Codes 32-37 count idle cycles and completion kinds.
// - Code 38 counts load multiple/string; zero-length only under single step.
// - Code 39 counts instruction table search cycles.
// - Code 40 counts data table search cycles beyond scaled threshold.
// - Code 42 adds completions matching masked breakpoint address.
// - Code 43 counts oldest miss queue cycles beyond scaled threshold.
// - Codes 45-47 count miss queue alias events.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module pces_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] compl_cnt,
  input wire logic [1:0] disp_cnt,
  input wire logic [31:0] timebase_lower,
  input wire logic monitor_ext_in,
  input wire logic other_counter_negative,
  input wire logic [3:0] vec_unit_done,
  input wire logic mtvstat_done,
  input wire logic mtvmask_done,
  input wire logic [3:0] vec_rs_wait,
  input wire logic mfvstat_hold,
  input wire logic vector_saturation_flag,
  input wire logic store_done,
  input wire logic icache_miss,
  input wire logic icache_access,
  input wire logic snoop_any,
  input wire logic snoop_hit_mod,
  input wire logic [2:0] snoop_castout,
  input wire logic [4:0] branch_ev,
  input wire logic [1:0] gpr_disp_cnt,
  input wire logic [5:0] iq_valid_cnt,
  input wire logic [5:0] viq_valid_cnt,
  input wire logic [4:0] compl_kind,
  input wire logic lsm_done,
  input wire logic lsx_zero_done,
  input wire logic single_step_trace_enable,
  input wire logic itlb_search,
  input wire logic dtlb_search,
  input wire logic lmq_oldest_busy,
  input wire logic [29:0] compl_addr_0,
  input wire logic [29:0] compl_addr_1,
  input wire logic [29:0] compl_addr_2,
  input wire logic [2:0] miss_alias_ev,
  output logic counting_active,
  output logic monitor_condition,
  output logic monitor_interrupt_req
);
  // ------------------------------------------------------------
  // Register bus slave
  // ------------------------------------------------------------
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] ctrl0_q, ctrl2_q, counter_q, bkpt_addr_q, bkpt_mask_q;
  logic count_en_q, cond_q, irq_q;
  logic [31:0] wmask, rd_mux;
  logic [7:0] wa, ra;
  logic wr_go, wr_ctrl0, wr_ctrl2, wr_cnt, wr_baddr, wr_bmask, wr_hit;
  logic rd_hit;

  assign awready = ~aw_q & ~bvalid_q;
  assign wready = ~w_q & ~bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = ~rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Address and data may arrive in either order; the write acts
  // only once both are held.
  assign wr_go = aw_q & w_q;
  assign wa = {waddr_q[7:2], 2'b00};
  assign ra = {araddr[7:2], 2'b00};
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_ctrl0 = wr_go && wa == pces_pkg::OFF_CTRL0;
  assign wr_ctrl2 = wr_go && wa == pces_pkg::OFF_CTRL2;
  assign wr_cnt = wr_go && wa == pces_pkg::OFF_COUNTER;
  assign wr_baddr = wr_go && wa == pces_pkg::OFF_BKPT_ADDR;
  assign wr_bmask = wr_go && wa == pces_pkg::OFF_BKPT_MASK;
  assign wr_hit = wr_ctrl0 | wr_ctrl2 | wr_cnt | wr_baddr | wr_bmask;

  always_comb begin
    rd_hit = 1'b1;
    case (ra)
      pces_pkg::OFF_CTRL0: rd_mux = ctrl0_q;
      pces_pkg::OFF_CTRL2: rd_mux = ctrl2_q;
      pces_pkg::OFF_COUNTER: rd_mux = counter_q;
      pces_pkg::OFF_BKPT_ADDR: rd_mux = bkpt_addr_q;
      pces_pkg::OFF_BKPT_MASK: rd_mux = bkpt_mask_q;
      pces_pkg::OFF_STATUS: rd_mux = {29'h0000_0000, irq_q, cond_q, count_en_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= pces_pkg::RESP_OKAY;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? pces_pkg::RESP_OKAY : pces_pkg::RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= pces_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? pces_pkg::RESP_OKAY : pces_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  logic [31:0] ctrl0_d;
  logic [6:0] sel;
  logic [1:0] timebase_bit_select;
  logic [5:0] thr;
  logic [4:0] tb_idx;
  logic [11:0] thr_scaled;

  assign ctrl0_d = ((ctrl0_q & ~wmask) | (wdata_q & wmask)) & pces_pkg::CTRL0_MASK;
  assign sel = ctrl0_q[pces_pkg::CTRL0_SEL_LSB +: pces_pkg::SEL_W];
  assign timebase_bit_select = ctrl0_q[pces_pkg::CTRL0_TIMEBASE_BIT_SELECT_LSB +: 2];
  assign thr = ctrl0_q[pces_pkg::CTRL0_THR_LSB +: pces_pkg::THR_W];
  assign thr_scaled = ctrl2_q[pces_pkg::CTRL2_MULT_BIT] ?
    {1'b0, thr, 5'h00} : {6'h00, thr};
  assign tb_idx = (timebase_bit_select == 2'h0) ? pces_pkg::TB_BIT0 :
                  (timebase_bit_select == 2'h1) ? pces_pkg::TB_BIT1 :
                  (timebase_bit_select == 2'h2) ? pces_pkg::TB_BIT2 : pces_pkg::TB_BIT3;

  // ------------------------------------------------------------
  // Event conditioning
  // ------------------------------------------------------------
  logic [3:0] edge_lvl, edge_rise;
  logic dtlb_over, lmq_over, cond_d;

  assign edge_lvl = {vector_saturation_flag, cond_q, monitor_ext_in,
                     timebase_lower[tb_idx]};

  pces_rise_det #(.W(4)) u_edges (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(edge_lvl),
    .rise(edge_rise)
  );

  pces_over_thresh #(.W(pces_pkg::TIMER_W)) u_dtlb_thr (
    .aclk(aclk),
    .aresetn(aresetn),
    .active(dtlb_search),
    .limit(thr_scaled),
    .over(dtlb_over)
  );

  pces_over_thresh #(.W(pces_pkg::TIMER_W)) u_lmq_thr (
    .aclk(aclk),
    .aresetn(aresetn),
    .active(lmq_oldest_busy),
    .limit(thr_scaled),
    .over(lmq_over)
  );

  // Breakpoint hits among the completing slots
  logic [29:0] cmp_addr [3];
  logic [29:0] bk_mask, bk_cmp;
  logic [1:0] bp_hits;
  assign cmp_addr[0] = compl_addr_0;
  assign cmp_addr[1] = compl_addr_1;
  assign cmp_addr[2] = compl_addr_2;
  assign bk_mask = bkpt_mask_q[31:2];
  assign bk_cmp = bkpt_addr_q[31:2] & bk_mask;

  always_comb begin
    bp_hits = 2'h0;
    for (int i = 0; i < 3; i++) begin
      if (2'(i) < compl_cnt && (cmp_addr[i] & bk_mask) == bk_cmp) begin
        bp_hits = bp_hits + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Event selection
  // ------------------------------------------------------------
  logic [1:0] ev_inc;
  logic [6:0] off_v, off_w, off_b, off_k, off_a, off_c;
  assign off_v = sel - pces_pkg::EV_VDONE_LO;
  assign off_w = sel - pces_pkg::EV_VWAIT_LO;
  assign off_b = sel - pces_pkg::EV_BR_LO;
  assign off_k = sel - pces_pkg::EV_KIND_LO;
  assign off_a = sel - pces_pkg::EV_ALIAS_LO;
  assign off_c = sel - pces_pkg::EV_CQ_LO;

  always_comb begin
    ev_inc = 2'h0;
    case (sel)
      pces_pkg::EV_CYCLES: ev_inc = 2'h1;
      pces_pkg::EV_COMPL: ev_inc = compl_cnt;
      pces_pkg::EV_TB_EDGE: ev_inc = {1'b0, edge_rise[0]};
      pces_pkg::EV_DISP: ev_inc = disp_cnt;
      pces_pkg::EV_COND: ev_inc = {1'b0, edge_rise[2]};
      pces_pkg::EV_EXT: ev_inc = {1'b0, edge_rise[1]};
      pces_pkg::EV_MTVSTAT: ev_inc = {1'b0, mtvstat_done};
      pces_pkg::EV_MTVMASK: ev_inc = {1'b0, mtvmask_done};
      pces_pkg::EV_MFV_HOLD: ev_inc = {1'b0, mfvstat_hold};
      pces_pkg::EV_SAT_EDGE: ev_inc = {1'b0, edge_rise[3]};
      pces_pkg::EV_STORE: ev_inc = {1'b0, store_done};
      pces_pkg::EV_IC_MISS: ev_inc = {1'b0, icache_miss};
      pces_pkg::EV_IC_ACC: ev_inc = {1'b0, icache_access};
      pces_pkg::EV_SNOOP: ev_inc = {1'b0, snoop_any};
      pces_pkg::EV_SNOOP_MOD: ev_inc = {1'b0, snoop_hit_mod};
      pces_pkg::EV_GPR_DISP: ev_inc = gpr_disp_cnt;
      pces_pkg::EV_DISP3: ev_inc = {1'b0, disp_cnt == 2'h3};
      pces_pkg::EV_IQ_THR: ev_inc = {1'b0, iq_valid_cnt >= thr};
      pces_pkg::EV_VIQ_THR: ev_inc = {1'b0, viq_valid_cnt >= thr};
      pces_pkg::EV_NO_COMPL: ev_inc = {1'b0, compl_cnt == 2'h0};
      pces_pkg::EV_LSM: ev_inc = {1'b0, lsm_done |
        (lsx_zero_done & single_step_trace_enable)};
      pces_pkg::EV_ITLB: ev_inc = {1'b0, itlb_search};
      pces_pkg::EV_DTLB: ev_inc = {1'b0, dtlb_over};
      pces_pkg::EV_BKPT: ev_inc = bp_hits;
      pces_pkg::EV_LMISS: ev_inc = {1'b0, lmq_over};
      default: begin
        // Reserved and unimplemented codes add nothing
        ev_inc = 2'h0;
        if (sel >= pces_pkg::EV_VDONE_LO && sel <= pces_pkg::EV_VDONE_HI) begin
          ev_inc = {1'b0, vec_unit_done[off_v[1:0]]};
        end
        if (sel >= pces_pkg::EV_VWAIT_LO && sel <= pces_pkg::EV_VWAIT_HI) begin
          ev_inc = {1'b0, vec_rs_wait[off_w[1:0]]};
        end
        if (sel >= pces_pkg::EV_BR_LO && sel <= pces_pkg::EV_BR_HI) begin
          ev_inc = {1'b0, branch_ev[off_b[2:0]]};
        end
        if (sel >= pces_pkg::EV_KIND_LO && sel <= pces_pkg::EV_KIND_HI) begin
          ev_inc = {1'b0, compl_kind[off_k[2:0]]};
        end
        if (sel >= pces_pkg::EV_ALIAS_LO && sel <= pces_pkg::EV_ALIAS_HI) begin
          ev_inc = {1'b0, miss_alias_ev[off_a[1:0]]};
        end
        if (sel >= pces_pkg::EV_CQ_LO && sel <= pces_pkg::EV_CQ_HI) begin
          ev_inc = {1'b0, snoop_castout[off_c[1:0]]};
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // Counter and monitor condition
  // ------------------------------------------------------------
  // Condition enable bits gate; the exception enable only gates the request
  assign cond_d = (counter_q[31] & ctrl0_q[pces_pkg::CTRL0_CE_BIT]) |
                  (other_counter_negative & ctrl0_q[pces_pkg::CTRL0_OCE_BIT]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q <= pces_pkg::CTRL0_RST;
      ctrl2_q <= pces_pkg::CTRL2_RST;
      bkpt_addr_q <= pces_pkg::BKPT_ADDR_RST;
      bkpt_mask_q <= pces_pkg::BKPT_MASK_RST;
    end else begin
      if (wr_ctrl0) ctrl0_q <= ctrl0_d;
      if (wr_ctrl2) ctrl2_q <= wdata_q & pces_pkg::CTRL2_MASK;
      if (wr_baddr) bkpt_addr_q <= wdata_q & pces_pkg::BKPT_MASK_BITS;
      if (wr_bmask) bkpt_mask_q <= wdata_q & pces_pkg::BKPT_MASK_BITS;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_q <= pces_pkg::COUNTER_RST;
      count_en_q <= 1'b0;
      cond_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cond_q <= cond_d;
      irq_q <= cond_d & ctrl0_q[pces_pkg::CTRL0_XE_BIT];
      // Software write wins over an interrupt in the same cycle
      if (wr_ctrl0) begin
        count_en_q <= (ctrl0_d != 32'h0000_0000);
      end else if (irq_q) begin
        count_en_q <= 1'b0;
      end
      if (wr_cnt) begin
        counter_q <= (counter_q & ~wmask) | (wdata_q & wmask);
      end else if (count_en_q) begin
        counter_q <= counter_q + {30'h0000_0000, ev_inc};
      end
    end
  end

  assign counting_active = count_en_q;
  assign monitor_condition = cond_q;
  assign monitor_interrupt_req = irq_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic live;
  assign live = count_en_q && !wr_cnt;

  sequence ext_low_s;
    sel == pces_pkg::EV_EXT && !monitor_ext_in;
  endsequence
  sequence ext_high_s;
    sel == pces_pkg::EV_EXT && monitor_ext_in && live;
  endsequence

  zero_sel_hold_a: assert property (
    sel == pces_pkg::EV_NONE && !wr_cnt |=> counter_q == $past(counter_q))
    else $error("counter moved with select zero");
  cycle_count_a: assert property (
    sel == pces_pkg::EV_CYCLES && live |=> counter_q == $past(counter_q) + 32'h1)
    else $error("cycle count did not add one");
  compl_add_a: assert property (
    sel == pces_pkg::EV_COMPL && live
    |=> counter_q == $past(counter_q) + {30'h0, $past(compl_cnt)})
    else $error("completion count mismatch");
  disp_add_a: assert property (
    sel == pces_pkg::EV_DISP && live
    |=> counter_q == $past(counter_q) + {30'h0, $past(disp_cnt)})
    else $error("dispatch count mismatch");
  ext_edge_a: assert property (
    ext_low_s ##1 ext_high_s |=> counter_q == $past(counter_q) + 32'h1)
    else $error("external edge not counted");
  reserved_hold_a: assert property (
    (sel == pces_pkg::EV_RSVD6 && !wr_cnt) [*2] |-> counter_q == $past(counter_q))
    else $error("reserved code changed counter");
  irq_stop_a: assert property (
    irq_q && !wr_ctrl0 |=> !count_en_q ##1 ($past(wr_ctrl0) || !count_en_q))
    else $error("counting continued after interrupt");
  ctrl_start_a: assert property (
    wr_ctrl0 && ctrl0_d != 32'h0 |=> count_en_q)
    else $error("counting did not start on control write");
endmodule : pces_top
`default_nettype wire

// ### src/pces_pkg.sv
package pces_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int SEL_W = 7;
  localparam int CNT_W = 32;
  localparam int THR_W = 6;
  localparam int AXI_AW = 8;
  localparam int THR_SCALE_SHIFT = 5;
  localparam int TIMER_W = 12;
  // ------------------------------------------------------------
  // Register offsets and fields
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_COUNTER = 8'h08;
  localparam logic [7:0] OFF_BKPT_ADDR = 8'h0C;
  localparam logic [7:0] OFF_BKPT_MASK = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam int CTRL0_SEL_LSB = 0;
  localparam int CTRL0_TIMEBASE_BIT_SELECT_LSB = 8;
  localparam int CTRL0_THR_LSB = 16;
  localparam int CTRL0_CE_BIT = 24;
  localparam int CTRL0_OCE_BIT = 25;
  localparam int CTRL0_XE_BIT = 26;
  localparam int CTRL2_MULT_BIT = 0;
  localparam logic [31:0] CTRL0_MASK = 32'h073F_037F;
  localparam logic [31:0] CTRL2_MASK = 32'h0000_0001;
  localparam logic [31:0] BKPT_MASK_BITS = 32'hFFFF_FFFC;
  localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
  localparam logic [31:0] COUNTER_RST = 32'h0000_0000;
  localparam logic [31:0] BKPT_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] BKPT_MASK_RST = 32'hFFFF_FFFC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timebase bit per select value, counted from the LSB
  localparam logic [4:0] TB_BIT0 = 5'h00;
  localparam logic [4:0] TB_BIT1 = 5'h08;
  localparam logic [4:0] TB_BIT2 = 5'h0C;
  localparam logic [4:0] TB_BIT3 = 5'h10;
  // ------------------------------------------------------------
  // Event select codes
  // ------------------------------------------------------------
  localparam logic [6:0] EV_NONE = 7'h00;
  localparam logic [6:0] EV_CYCLES = 7'h01;
  localparam logic [6:0] EV_COMPL = 7'h02;
  localparam logic [6:0] EV_TB_EDGE = 7'h03;
  localparam logic [6:0] EV_DISP = 7'h04;
  localparam logic [6:0] EV_COND = 7'h05;
  localparam logic [6:0] EV_RSVD6 = 7'h06;
  localparam logic [6:0] EV_EXT = 7'h07;
  localparam logic [6:0] EV_VDONE_LO = 7'h08;
  localparam logic [6:0] EV_VDONE_HI = 7'h0B;
  localparam logic [6:0] EV_MTVSTAT = 7'h0C;
  localparam logic [6:0] EV_MTVMASK = 7'h0D;
  localparam logic [6:0] EV_VWAIT_LO = 7'h0E;
  localparam logic [6:0] EV_VWAIT_HI = 7'h11;
  localparam logic [6:0] EV_MFV_HOLD = 7'h12;
  localparam logic [6:0] EV_SAT_EDGE = 7'h13;
  localparam logic [6:0] EV_STORE = 7'h14;
  localparam logic [6:0] EV_IC_MISS = 7'h15;
  localparam logic [6:0] EV_SNOOP = 7'h16;
  localparam logic [6:0] EV_BR_LO = 7'h17;
  localparam logic [6:0] EV_BR_HI = 7'h1B;
  localparam logic [6:0] EV_GPR_DISP = 7'h1C;
  localparam logic [6:0] EV_DISP3 = 7'h1D;
  localparam logic [6:0] EV_IQ_THR = 7'h1E;
  localparam logic [6:0] EV_VIQ_THR = 7'h1F;
  localparam logic [6:0] EV_NO_COMPL = 7'h20;
  localparam logic [6:0] EV_KIND_LO = 7'h21;
  localparam logic [6:0] EV_KIND_HI = 7'h25;
  localparam logic [6:0] EV_LSM = 7'h26;
  localparam logic [6:0] EV_ITLB = 7'h27;
  localparam logic [6:0] EV_DTLB = 7'h28;
  localparam logic [6:0] EV_IC_ACC = 7'h29;
  localparam logic [6:0] EV_BKPT = 7'h2A;
  localparam logic [6:0] EV_LMISS = 7'h2B;
  localparam logic [6:0] EV_SNOOP_MOD = 7'h2C;
  localparam logic [6:0] EV_ALIAS_LO = 7'h2D;
  localparam logic [6:0] EV_ALIAS_HI = 7'h2F;
  localparam logic [6:0] EV_CQ_LO = 7'h30;
  localparam logic [6:0] EV_CQ_HI = 7'h32;
endpackage : pces_pkg

// ### src/pces_rise_det.sv
`timescale 1ns/100ps
`default_nettype none
module pces_rise_det #(
  parameter int W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] prev_q;
  logic primed_q;

  if (W < 1) begin : g_chk
    $error("pces_rise_det: W must be at least 1");
  end

  // No edge is reported in the first cycle after reset: the
  // previous level is not yet known.
  assign rise = level & ~prev_q & {W{primed_q}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= '0;
      primed_q <= 1'b0;
    end else begin
      prev_q <= level;
      primed_q <= 1'b1;
    end
  end
endmodule : pces_rise_det
`default_nettype wire

// ### src/pces_over_thresh.sv
`timescale 1ns/100ps
`default_nettype none
module pces_over_thresh #(
  parameter int W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic active,
  input wire logic [W-1:0] limit,
  output logic over
);
  logic [W-1:0] elapsed_q;

  if (W < 2) begin : g_chk
    $error("pces_over_thresh: W must be at least 2");
  end

  // Cycle i of an active stretch (from 0) is over once i >= limit
  assign over = active && (elapsed_q >= limit);

  // Saturates so a very long search never wraps back under the limit
  always_ff @(posedge aclk) begin
    if (!aresetn || !active) begin
      elapsed_q <= '0;
    end else if (elapsed_q != {W{1'b1}}) begin
      elapsed_q <= elapsed_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  first_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(active) && limit != '0 |-> !over)
    else $error("over asserted in first active cycle");
endmodule : pces_over_thresh
`default_nettype wire

// ### bench/pces_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Core event source model
// ----------------------------------------
module pces_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic [1:0] compl_cnt,
  output logic [1:0] disp_cnt,
  output logic monitor_ext_in,
  output logic [31:0] timebase_lower,
  output logic [31:0] ev_lvl
);
  // Quiet while stopped, so every count is exact
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      compl_cnt <= 2'h0;
      disp_cnt <= 2'h0;
      monitor_ext_in <= 1'b0;
      ev_lvl <= 32'h0000_0000;
    end else begin
      // Every other event line stands high for the whole window
      ev_lvl <= 32'hFFFF_FFFF;
      compl_cnt <= 2'h3;
      disp_cnt <= 2'h2;
      monitor_ext_in <= !monitor_ext_in;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timebase_lower <= 32'h0000_0000;
    end else if (run) begin
      timebase_lower <= timebase_lower + 32'h0000_0001;
    end
  end
endmodule : pces_core_model
`default_nettype wire

// ### bench/perf_counter_event_select_bench.sv
`timescale 1ns/100ps
`default_nettype none
module perf_counter_event_select_bench;
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, timebase_lower, got, ev;
  logic counting_active, monitor_condition, monitor_interrupt_req;
  logic [1:0] bresp, rresp, compl_cnt, disp_cnt, resp;
  logic awready, wready, bvalid, arready, rvalid, monitor_ext_in;
  int failures = 0, check_count = 0, cycles = 0;
  // Preset, control word, expected count after eight event cycles
  logic [31:0] pre [16] = '{0, 0, 0, 0, 0, 0, 32'h8000_0000, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  logic [31:0] ctl [16] = '{32'h100, 2, 3, 4, 6, 7, 32'h0500_0005, 8, 19, 28, 32'h0001_001E,
    32'h0003_0028, 32'h0002_002B, 48, 38, 42};
  logic [31:0] exp_cnt [16] = '{0, 24, 4, 16, 0, 4, 32'h8000_0001, 8, 1, 24, 8, 5, 6, 8, 8, 24};
  pces_core_model model (.aclk(aclk), .aresetn(aresetn), .run(run), .compl_cnt(compl_cnt),
    .disp_cnt(disp_cnt), .monitor_ext_in(monitor_ext_in), .timebase_lower(timebase_lower),
    .ev_lvl(ev));
  pces_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .compl_cnt(compl_cnt), .disp_cnt(disp_cnt), .timebase_lower(timebase_lower),
    .monitor_ext_in(monitor_ext_in), .other_counter_negative(1'b0), .vec_unit_done(ev[3:0]),
    .mtvstat_done(ev[0]), .mtvmask_done(ev[1]), .vec_rs_wait(ev[3:0]), .mfvstat_hold(ev[2]),
    .vector_saturation_flag(ev[3]), .store_done(ev[4]), .icache_miss(ev[5]),
    .icache_access(ev[6]), .snoop_any(ev[7]), .snoop_hit_mod(ev[8]), .snoop_castout(ev[2:0]),
    .branch_ev(ev[4:0]), .gpr_disp_cnt(ev[1:0]), .iq_valid_cnt(ev[5:0]),
    .viq_valid_cnt(ev[5:0]), .compl_kind(ev[4:0]), .lsm_done(ev[9]), .lsx_zero_done(ev[10]),
    .itlb_search(ev[11]), .single_step_trace_enable(ev[12]), .dtlb_search(ev[13]),
    .lmq_oldest_busy(ev[14]), .compl_addr_0(ev[29:0]), .compl_addr_1(ev[29:0]),
    .compl_addr_2(ev[29:0]), .miss_alias_ev(ev[2:0]), .counting_active(counting_active),
    .monitor_condition(monitor_condition), .monitor_interrupt_req(monitor_interrupt_req));
  initial begin
    forever #5 aclk = !aclk;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : bus_read
  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check_word
  // Events only flow while run is high, eight cycles at a time
  task automatic run_events();
    run <= 1'b1;
    repeat (8) @(posedge aclk);
    run <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : run_events
  task automatic close_out();
    $display("failures %0d, check_count %0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    bus_read(pces_pkg::OFF_CTRL0);
    check_word(got, pces_pkg::CTRL0_RST);
    bus_read(8'h40);
    check_word({30'h0, resp}, {30'h0, pces_pkg::RESP_SLVERR});
    bus_write(pces_pkg::OFF_BKPT_ADDR, 32'hFFFF_FFFC);
    for (int i = 0; i < 16; i++) begin
      bus_write(pces_pkg::OFF_COUNTER, pre[i]);
      bus_write(pces_pkg::OFF_CTRL0, ctl[i]);
      run_events();
      bus_read(pces_pkg::OFF_COUNTER);
      check_word(got, exp_cnt[i]);
      if (i == 6) check_word({29'h0, monitor_interrupt_req, monitor_condition,
        counting_active}, 32'h6);
      bus_write(pces_pkg::OFF_CTRL0, 32'h0000_0000);
    end
    bus_write(pces_pkg::OFF_COUNTER, 32'h0000_0000);
    bus_write(pces_pkg::OFF_CTRL0, 32'h0000_0002);
    run_events();
    bus_read(pces_pkg::OFF_STATUS);
    check_word(got & 32'h1, 32'h1);
    bus_write(pces_pkg::OFF_CTRL0, 32'h0000_0000);
    run_events();
    bus_read(pces_pkg::OFF_COUNTER);
    check_word(got, 32'h0000_0018);
    close_out();
  end
endmodule : perf_counter_event_select_bench
`default_nettype wire
